// ### rtl/dp_slave_cfg_diag.sv
// configuration check, diagnosis framing and service gating of the slave
// assumes link octet streams and requests synchronous to clock
`timescale 1ns/100ps
`default_nettype none
module dp_slave_cfg_diag
  import dp_slave_pkg::*;
#(
  parameter int          MAX_IN_LEN  = 244,    // permitted input bytes
  parameter int          MAX_OUT_LEN = 244,    // permitted output bytes
  parameter logic [15:0] IDENT_CODE  = 16'h0F0F // arbitrary value
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,        // register byte address
  input  wire logic [31:0] wdata,       // register write data
  input  wire logic        wr_stb,      // register write strobe
  input  wire logic        rd_stb,      // register read strobe
  output logic      [31:0] rdata,       // read data, cycle after strobe
  input  wire octet_type   prm_in,      // parameterization octets
  input  wire octet_type   cfg_in,      // configuration octets
  input  wire logic        diag_req,    // diagnostic poll
  output octet_type        diag_out,    // diagnosis octets
  input  wire svc_req_type svc_in,      // service request
  output logic             svc_done,    // request accepted, pulse
  output logic             svc_refused, // request refused, pulse
  input  wire logic        err_valid,   // internal error event
  input  wire logic [7:0]  err_num,     // internal error number
  output logic             xchg_ready,  // cyclic exchange allowed
  output logic             len_is_max,  // lengths are maxima
  output logic      [12:0] in_len,      // checked input bytes
  output logic      [12:0] out_len      // checked output bytes
);

  // refuse limits the length counters cannot hold
  if (MAX_IN_LEN < 1 || MAX_IN_LEN > 4095 ||
      MAX_OUT_LEN < 1 || MAX_OUT_LEN > 4095) begin : g_bad_len
    $error("length limits out of range");
  end

  localparam logic [12:0] MAX_IN  = 13'(MAX_IN_LEN);
  localparam logic [12:0] MAX_OUT = 13'(MAX_OUT_LEN);

  // whole state of the block
  typedef struct packed {
    diag_state_type dst;       // diagnosis sender state
    logic [3:0]     idx;       // diagnosis byte index
    logic           snap_v1;   // mode at poll
    logic           snap_ext;  // error part present at poll
    logic [7:0]     snap_err;  // error number at poll
    octet_type      dout;      // diagnosis output
    logic           cfg_busy;  // inside a configuration telegram
    logic [12:0]    acc_in;    // running input bytes
    logic [12:0]    acc_out;   // running output bytes
    logic [12:0]    in_len;    // committed input bytes
    logic [12:0]    out_len;   // committed output bytes
    logic           cfg_ok;    // last configuration passed
    logic           cfg_fault; // last configuration failed
    logic           prm_done;  // parameterized
    logic [7:0]     prm_cnt;   // parameter octet index
    logic           dpv1;      // extended mode selected
    logic           len_max;   // length byte option
    logic           ext_diag;  // external diagnosis pending
    logic [7:0]     err;       // latched error number
    logic           ready;     // cyclic exchange allowed
    logic           c2_open;   // class two channel open
    logic           c2_used;   // class two transfer done
    logic           svc_done;  // accept pulse
    logic           svc_ref;   // refuse pulse
    logic [31:0]    rdata;     // read data
  } state_type;

  state_type q;  // registered state
  state_type d;  // next state

  logic [12:0] unit_cnt;  // units of current octet
  logic [12:0] oct_bytes; // bytes of current octet
  logic [12:0] sum_in;    // input total with this octet
  logic [12:0] sum_out;   // output total with this octet
  logic        fault_now; // total over the limit

  // identifier octet size and running totals
  always_comb begin
    unit_cnt  = 13'(cfg_in.data[3:0]) + 13'h0001;
    oct_bytes = cfg_in.data[ID_WORD_BIT] ? {unit_cnt[11:0], 1'b0} : unit_cnt;
    // a shared octet counts toward both directions
    sum_in  = (q.cfg_busy ? q.acc_in : 13'h0000) +
              (cfg_in.data[ID_IN_BIT] ? oct_bytes : 13'h0000);
    sum_out = (q.cfg_busy ? q.acc_out : 13'h0000) +
              (cfg_in.data[ID_OUT_BIT] ? oct_bytes : 13'h0000);
    fault_now = (sum_in > MAX_IN) || (sum_out > MAX_OUT);
  end

  // next state
  always_comb begin
    d = q;
    d.svc_done = 1'b0;
    d.svc_ref  = 1'b0;
    d.rdata    = 32'h0000_0000;

    // parameterization octets
    if (prm_in.valid) begin
      d.prm_cnt = q.prm_cnt + 8'h01;
      if (q.prm_cnt == 8'h00) begin
        d.dpv1 = 1'b0; // short telegram means basic mode
      end
      if (q.prm_cnt == PRM_EXT_INDEX) begin
        d.dpv1 = prm_in.data[PRM_EXT_BIT];
      end
      if (prm_in.last) begin
        d.prm_cnt  = 8'h00;
        d.prm_done = 1'b1;
        d.cfg_ok   = 1'b0; // new configuration must follow
        d.ready    = 1'b0;
        d.c2_open  = 1'b0;
        d.c2_used  = 1'b0;
      end
    end

    // configuration octets
    if (cfg_in.valid) begin
      d.cfg_busy = ~cfg_in.last;
      d.acc_in   = sum_in;
      d.acc_out  = sum_out;
      d.ready    = 1'b0;
      if (cfg_in.last) begin
        // lengths kept as exact sums whatever the length byte option
        d.in_len    = sum_in;
        d.out_len   = sum_out;
        d.cfg_fault = fault_now;
        d.cfg_ok    = ~fault_now &
                      (q.prm_done | (prm_in.valid & prm_in.last));
      end
    end

    // internal error, set wins over clear
    if (wr_stb && addr == REG_CONTROL && wdata[CTL_CLR_EXT]) begin
      d.ext_diag = 1'b0;
    end
    if (err_valid) begin
      d.ext_diag = 1'b1;
      d.err      = err_num;
    end

    // register writes and reads
    if (wr_stb && addr == REG_CONTROL) begin
      d.len_max = wdata[CTL_LEN_MAX];
    end
    if (rd_stb) begin
      case (addr)
        REG_CONTROL: begin
          d.rdata[CTL_LEN_MAX] = q.len_max;
        end
        REG_STATUS: begin
          d.rdata[STS_READY]     = q.ready;
          d.rdata[STS_CFG_FAULT] = q.cfg_fault;
          d.rdata[STS_DPV1]      = q.dpv1;
          d.rdata[STS_EXT_DIAG]  = q.ext_diag;
          d.rdata[STS_C2_OPEN]   = q.c2_open;
          d.rdata[STS_PRM_DONE]  = q.prm_done;
          d.rdata[STS_CFG_OK]    = q.cfg_ok;
        end
        REG_LENGTHS: begin
          d.rdata = {3'b000, q.out_len, 3'b000, q.in_len};
        end
        REG_ERROR: begin
          d.rdata = {24'h00_0000, q.err};
        end
        default: begin
          d.rdata = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end

    // service gating
    if (svc_in.valid) begin
      d.svc_ref = 1'b1;
      case (svc_in.code)
        SVC_C1_READ, SVC_C1_WRITE: begin
          // channel fixed once the extended mode is parameterized
          if (q.prm_done && q.dpv1) begin
            d.svc_ref  = 1'b0;
          end
        end
        SVC_C2_OPEN: begin
          if (q.prm_done && q.dpv1 && !q.c2_open) begin
            d.svc_ref = 1'b0;
            d.c2_open = 1'b1;
            d.c2_used = 1'b0;
          end
        end
        SVC_C2_READ, SVC_C2_WRITE: begin
          // one transfer per opening
          if (q.c2_open && !q.c2_used) begin
            d.svc_ref = 1'b0;
            d.c2_used = 1'b1;
          end
        end
        SVC_C2_CLOSE: begin
          if (q.c2_open) begin
            d.svc_ref = 1'b0;
            d.c2_open = 1'b0;
            d.c2_used = 1'b0;
          end
        end
        SVC_DXB_PUB: begin
          if (q.ready) begin
            d.svc_ref = 1'b0;
          end
        end
        default: begin
          // alarms, isochronous, subscriber, upload and the rest
          d.svc_ref = 1'b1;
        end
      endcase
      d.svc_done = ~d.svc_ref;
    end

    // diagnosis sender
    d.dout = '0;
    case (q.dst)
      DG_IDLE: begin
        if (diag_req) begin
          d.dst      = DG_STD;
          d.idx      = 4'h0;
          d.snap_v1  = q.dpv1;
          d.snap_ext = q.ext_diag;
          d.snap_err = q.err;
          // ready after a clean configuration; an octet in flight keeps
          // it low, so a poll beside a failing telegram cannot open it
          d.ready    = d.cfg_ok & d.prm_done &
                       ~cfg_in.valid;
        end
      end
      DG_STD: begin
        d.dout.valid = 1'b1;
        case (q.idx)
          4'h0: begin
            d.dout.data = DIAG_ZERO;
            d.dout.data[ST1_NOT_READY] = ~q.ready;
            d.dout.data[ST1_CFG_FAULT] = q.cfg_fault;
            d.dout.data[ST1_EXT_DIAG]  = q.snap_ext;
          end
          4'h1: begin
            d.dout.data = DIAG_ZERO;
            d.dout.data[ST2_PRM_REQ]   = ~q.prm_done;
            d.dout.data[ST2_FIXED_ONE] = 1'b1;
          end
          4'h3: d.dout.data = DIAG_NO_MASTER;
          4'h4: d.dout.data = IDENT_CODE[15:8];
          4'h5: d.dout.data = IDENT_CODE[7:0];
          default: d.dout.data = DIAG_ZERO;
        endcase
        d.idx = q.idx + 4'h1;
        if (q.idx == DIAG_STD_LAST) begin
          d.dout.last = ~q.snap_ext;
          d.dst       = q.snap_ext ? DG_EXT : DG_IDLE;
        end
      end
      DG_EXT: begin
        d.dout.valid = 1'b1;
        d.idx        = q.idx + 4'h1;
        if (!q.snap_v1) begin
          d.dout.data = q.snap_err;
          d.dout.last = 1'b1;
          d.dst       = DG_IDLE;
        end else begin
          // status header so the error number lands in the fourth byte
          case (q.idx)
            DIAG_EXT_FIRST: d.dout.data = DIAG_V1_HEAD;
            DIAG_V1_LAST:   d.dout.data = q.snap_err;
            default:        d.dout.data = DIAG_V1_PAD;
          endcase
          if (q.idx == DIAG_V1_LAST) begin
            d.dout.last = 1'b1;
            d.dst       = DG_IDLE;
          end
        end
      end
      default: begin
        d.dst = DG_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      q     <= '0;
      q.dst <= DG_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign rdata       = q.rdata;
  assign diag_out    = q.dout;
  assign svc_done    = q.svc_done;
  assign svc_refused = q.svc_ref;
  assign xchg_ready  = q.ready;
  assign len_is_max  = q.len_max;
  assign in_len      = q.in_len;
  assign out_len     = q.out_len;

  // checks
  chk_fault_blocks: assert property (@(posedge clock) disable iff (rst)
    q.cfg_fault |-> !xchg_ready)
    else $error("exchange ready despite configuration fault");
  chk_fault_kept: assert property (@(posedge clock) disable iff (rst)
    q.cfg_fault && !cfg_in.valid |=> q.cfg_fault)
    else $error("configuration fault dropped without new telegram");
  chk_error_flag: assert property (@(posedge clock) disable iff (rst)
    err_valid |=> q.ext_diag && q.err == $past(err_num))
    else $error("internal error not latched");
  chk_std_bytes: assert property (@(posedge clock) disable iff (rst)
    q.dst == DG_IDLE && diag_req |=> ##1 (diag_out.valid[*6]))
    else $error("standard diagnosis not six bytes");
  chk_basic_part: assert property (@(posedge clock) disable iff (rst)
    q.dst == DG_EXT && !q.snap_v1 |=>
      diag_out.valid && diag_out.last && diag_out.data == $past(q.snap_err))
    else $error("basic error byte wrong");
  chk_ext_header: assert property (@(posedge clock) disable iff (rst)
    q.dst == DG_EXT && q.snap_v1 && q.idx == DIAG_EXT_FIRST |=>
      diag_out.data == DIAG_V1_HEAD ##1 diag_out.data == DIAG_V1_PAD
      ##1 diag_out.data == DIAG_V1_PAD ##1 diag_out.last)
    else $error("extended diagnosis header wrong");
  chk_iso_refused: assert property (@(posedge clock) disable iff (rst)
    svc_in.valid && svc_in.code == SVC_ISOCHRON |=> svc_refused && !svc_done)
    else $error("isochronous request accepted");
  chk_sub_refused: assert property (@(posedge clock) disable iff (rst)
    svc_in.valid && svc_in.code == SVC_DXB_SUB |=> svc_refused)
    else $error("subscriber request accepted");
  chk_alarm_refused: assert property (@(posedge clock) disable iff (rst)
    svc_in.valid && svc_in.code == SVC_ALARM_ACK |=> svc_refused)
    else $error("alarm request accepted");
  chk_c2_closed: assert property (@(posedge clock) disable iff (rst)
    svc_in.valid && svc_in.code == SVC_C2_READ && !q.c2_open |=> svc_refused)
    else $error("class two transfer on closed channel");
  chk_c1_basic: assert property (@(posedge clock) disable iff (rst)
    svc_in.valid && svc_in.code == SVC_C1_READ && !q.dpv1 |=> svc_refused)
    else $error("class one transfer in basic mode");

endmodule : dp_slave_cfg_diag
`default_nettype wire

// ### rtl/dp_slave_pkg.sv
// constants, codes and carrier types of the fieldbus slave block
// assumes a byte-wide link front end that delivers telegram octets
package dp_slave_pkg;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_LENGTHS = 8'h08;
  localparam logic [7:0] REG_ERROR   = 8'h0C;

  // control register fields
  localparam int CTL_LEN_MAX   = 0;  // lengths are maxima
  localparam int CTL_CLR_EXT   = 1;  // write one clears external diagnosis

  // status register fields
  localparam int STS_READY     = 0;
  localparam int STS_CFG_FAULT = 1;
  localparam int STS_DPV1      = 2;
  localparam int STS_EXT_DIAG  = 3;
  localparam int STS_C2_OPEN   = 4;
  localparam int STS_PRM_DONE  = 5;
  localparam int STS_CFG_OK    = 6;

  // lengths register field position
  localparam int LEN_OUT_POS   = 16;

  // parameterization: octet 8 (index 7), bit 7 enables the extended mode
  localparam logic [7:0] PRM_EXT_INDEX = 8'h07;
  localparam int         PRM_EXT_BIT   = 7;

  // identifier octet fields
  localparam int ID_IN_BIT   = 4;
  localparam int ID_OUT_BIT  = 5;
  localparam int ID_WORD_BIT = 6;

  // diagnosis layout
  localparam logic [3:0] DIAG_STD_LAST  = 4'h5;  // six standard bytes
  localparam logic [3:0] DIAG_EXT_FIRST = 4'h6;
  localparam logic [3:0] DIAG_V1_LAST   = 4'h9;  // four-byte part
  localparam logic [7:0] DIAG_V1_HEAD   = 8'h81;
  localparam logic [7:0] DIAG_V1_PAD    = 8'h00;
  localparam logic [7:0] DIAG_NO_MASTER = 8'hFF;
  localparam logic [7:0] DIAG_ZERO      = 8'h00;
  localparam int ST1_NOT_READY = 1;
  localparam int ST1_CFG_FAULT = 2;
  localparam int ST1_EXT_DIAG  = 3;
  localparam int ST2_PRM_REQ   = 0;
  localparam int ST2_FIXED_ONE = 2;

  // acyclic and extended service requests
  typedef enum logic [3:0] {
    SVC_C1_READ   = 4'h0, SVC_C1_WRITE = 4'h1,
    SVC_C2_OPEN   = 4'h2, SVC_C2_READ  = 4'h3,
    SVC_C2_WRITE  = 4'h4, SVC_C2_CLOSE = 4'h5,
    SVC_ALARM_ACK = 4'h6, SVC_ISOCHRON = 4'h7,
    SVC_DXB_PUB   = 4'h8, SVC_DXB_SUB  = 4'h9,
    SVC_UPLOAD    = 4'hA, SVC_DOWNLOAD = 4'hB,
    SVC_TIME_SYNC = 4'hC, SVC_REDUND   = 4'hD
  } svc_code_type;

  // diagnosis sender states, gray from idle through standard to extended
  typedef enum logic [1:0] {
    DG_IDLE = 2'b00, DG_STD = 2'b01, DG_EXT = 2'b11
  } diag_state_type;

  // octet stream from the link
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } octet_type;

  // service request from the link
  typedef struct packed {
    logic         valid;
    svc_code_type code;
  } svc_req_type;

endpackage : dp_slave_pkg

// ### tb/dp_master.sv
// master-side model: sends telegrams, polls diagnosis, issues services
// assumes the slave answers one or two clocks after each request edge
`timescale 1ns/100ps
`default_nettype none
module dp_master
  import dp_slave_pkg::*;
(
  input  wire logic        clock,       // bench clock
  output var  octet_type   prm_out,     // parameterization octets
  output var  octet_type   cfg_out,     // configuration octets
  output var  logic        diag_req,    // diagnostic poll
  input  wire octet_type   diag_in,     // diagnosis octets
  output var  svc_req_type svc_out,     // service request
  input  wire logic        svc_done,    // accepted pulse
  input  wire logic        svc_refused  // refused pulse
);
  logic [7:0] dbytes [0:9]; // captured diagnosis bytes
  int         dcount;       // bytes captured in last poll
  logic       timed_out;    // last poll never saw its final byte

  // idle link at time zero
  initial begin
    prm_out  = '0;
    cfg_out  = '0;
    diag_req = 1'b0;
    svc_out  = '0;
  end

  // eight octets, octet 8 bit 7 picks the extended mode
  task automatic send_prm(input logic ext);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      prm_out <= '{1'b1, (i == 7) ? {ext, 7'h00} : 8'h00, i == 7};
    end
    @(posedge clock);
    // released line shows the inverse, not a stale value
    prm_out <= '{1'b0, ~prm_out.data, 1'b0};
  endtask

  // two identifier octets, sent only after parameterization
  task automatic send_cfg(input logic [7:0] a, input logic [7:0] b);
    @(posedge clock);
    cfg_out <= '{1'b1, a, 1'b0};
    @(posedge clock);
    cfg_out <= '{1'b1, b, 1'b1};
    @(posedge clock);
    cfg_out <= '{1'b0, ~b, 1'b0};
  endtask

  // one poll; the error byte is taken as the final byte received
  task automatic poll();
    dcount    = 0;
    timed_out = 1'b1;
    @(posedge clock);
    diag_req <= 1'b1;
    @(posedge clock);
    diag_req <= 1'b0;
    for (int i = 0; i < 20 && timed_out; i++) begin
      @(posedge clock);
      if (diag_in.valid === 1'b1 && dcount < 10) begin
        dbytes[dcount] = diag_in.data;
        dcount++;
        if (diag_in.last === 1'b1) timed_out = 1'b0;
      end
    end
  endtask

  // one service request; answer is {done, refused}
  task automatic service(input svc_code_type c, output logic [1:0] ans);
    @(posedge clock);
    svc_out <= '{1'b1, c};
    @(posedge clock);
    svc_out <= '0;
    @(posedge clock);
    ans = {svc_done, svc_refused};
  endtask
endmodule // dp_master
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the slave configuration and diagnosis block
// assumes the master model drives the link side, bench owns registers
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import dp_slave_pkg::*;
();
  localparam int          MAX_LEN = 32;       // shortened length limit
  localparam logic [15:0] IDENT   = 16'h5AA5; // arbitrary value
  logic        clock = 1'b0;  // 10 MHz
  logic        rst   = 1'b1;  // synchronous reset
  logic [7:0]  addr  = 8'h00; // register address
  logic [31:0] wdata = 32'h0; // register write data
  logic        wr_stb = 1'b0, rd_stb = 1'b0, err_valid = 1'b0;
  logic [7:0]  err_num = 8'h00;
  logic [31:0] rdata, rv;
  octet_type   prm, cfg, diag;
  svc_req_type svc;
  logic        diag_req, svc_done, svc_refused, xchg_ready, len_is_max;
  logic [12:0] in_len, out_len;
  logic [1:0]  ans;
  int          n_fail = 0;
  int          total_checks = 0;

  always #50 clock = ~clock;

  dp_slave_cfg_diag #(.MAX_IN_LEN(MAX_LEN), .MAX_OUT_LEN(MAX_LEN),
    .IDENT_CODE(IDENT)) u_dp_slave_cfg_diag (.clock(clock), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .prm_in(prm), .cfg_in(cfg), .diag_req(diag_req),
    .diag_out(diag), .svc_in(svc), .svc_done(svc_done),
    .svc_refused(svc_refused), .err_valid(err_valid), .err_num(err_num),
    .xchg_ready(xchg_ready), .len_is_max(len_is_max), .in_len(in_len),
    .out_len(out_len));
  dp_master u_dp_master (.clock(clock), .prm_out(prm), .cfg_out(cfg),
    .diag_req(diag_req), .diag_in(diag), .svc_out(svc),
    .svc_done(svc_done), .svc_refused(svc_refused));

  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(posedge clock);
    rv = rdata;
    chk("register", exp, rv);
  endtask

  task automatic raise_err(input logic [7:0] n);
    @(posedge clock);
    err_valid <= 1'b1;
    err_num   <= n;
    @(posedge clock);
    err_valid <= 1'b0;
  endtask

  // poll and compare; extra is 0, 1 or 4 error-part bytes
  task automatic diag_expect(input logic [7:0] st1, input int extra,
                             input logic [7:0] e);
    logic [7:0] x [0:9];
    x = '{st1, 8'h04, 8'h00, 8'hFF, IDENT[15:8], IDENT[7:0],
          8'h81, 8'h00, 8'h00, e};
    if (extra == 1) x[6] = e;
    u_dp_master.poll();
    if (u_dp_master.timed_out === 1'b1) begin
      n_fail++;
      results();
    end
    chk("diag count", 6 + extra, u_dp_master.dcount);
    for (int i = 0; i < 6 + extra; i++)
      chk("diag byte", x[i], u_dp_master.dbytes[i]);
  endtask

  task automatic cfg_expect(input logic [7:0] a, b,
                            input logic [12:0] ei, eo);
    u_dp_master.send_cfg(a, b);
    @(posedge clock);
    chk("in_len", ei, in_len);
    chk("out_len", eo, out_len);
  endtask

  task automatic svc_expect(input svc_code_type c, input logic [1:0] exp);
    u_dp_master.service(c, ans);
    chk("service answer", exp, ans);
  endtask

  // reset state, unmapped place, first parameterization in basic mode
  task automatic t_basic();
    rchk(REG_STATUS, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rchk(8'h10, 32'h0);
    u_dp_master.send_prm(1'b0);
    rchk(REG_STATUS, 32'h20);
    diag_expect(8'h02, 0, 8'h00);
    chk("ready", 32'h0, xchg_ready);
    cfg_expect(8'h3F, 8'h50, 13'd18, 13'd16);
    cfg_expect(8'h1F, 8'h2F, 13'd16, 13'd16);
    rchk(REG_LENGTHS, 32'h0010_0010);
    diag_expect(8'h00, 0, 8'h00);
    chk("ready", 32'h1, xchg_ready);
    svc_expect(SVC_C1_READ, 2'b01);
    svc_expect(SVC_DXB_PUB, 2'b10);
  endtask

  // limit boundary, faults in both directions, recovery
  task automatic t_fault();
    cfg_expect(8'h5F, 8'h2F, 13'd32, 13'd16);
    diag_expect(8'h00, 0, 8'h00);
    cfg_expect(8'h5F, 8'h10, 13'd33, 13'd0);
    diag_expect(8'h06, 0, 8'h00);
    chk("ready", 32'h0, xchg_ready);
    rchk(REG_STATUS, 32'h22);
    svc_expect(SVC_DXB_PUB, 2'b01);
    cfg_expect(8'h6F, 8'h20, 13'd0, 13'd33);
    diag_expect(8'h06, 0, 8'h00);
    cfg_expect(8'h1F, 8'h6F, 13'd16, 13'd32);
    diag_expect(8'h00, 0, 8'h00);
    chk("ready", 32'h1, xchg_ready);
    wr(REG_CONTROL, 32'h1);
    @(posedge clock);
    chk("len_is_max", 32'h1, len_is_max);
    rchk(REG_CONTROL, 32'h1);
    cfg_expect(8'h1F, 8'h6F, 13'd16, 13'd32);
  endtask

  // internal error in basic mode, then cleared
  task automatic t_err();
    raise_err(8'h2A);
    rchk(REG_ERROR, 32'h2A);
    diag_expect(8'h08, 1, 8'h2A);
    wr(REG_CONTROL, 32'h2);
    @(posedge clock);
    chk("len_is_max", 32'h0, len_is_max);
    diag_expect(8'h00, 0, 8'h00);
  endtask

  // extended mode: four-byte error part and acyclic services
  task automatic t_ext();
    svc_code_type no [0:5];
    no = '{SVC_ALARM_ACK, SVC_ISOCHRON, SVC_UPLOAD, SVC_DOWNLOAD,
           SVC_TIME_SYNC, SVC_REDUND};
    u_dp_master.send_prm(1'b1);
    rchk(REG_STATUS, 32'h24);
    cfg_expect(8'h1F, 8'h2F, 13'd16, 13'd16);
    svc_expect(SVC_DXB_PUB, 2'b01);
    raise_err(8'hC3);
    diag_expect(8'h08, 4, 8'hC3);
    svc_expect(SVC_C1_READ, 2'b10);
    svc_expect(SVC_C1_WRITE, 2'b10);
    svc_expect(SVC_C2_READ, 2'b01);
    svc_expect(SVC_C2_OPEN, 2'b10);
    rchk(REG_STATUS, 32'h7D);
    svc_expect(SVC_C2_READ, 2'b10);
    svc_expect(SVC_C2_WRITE, 2'b01);
    svc_expect(SVC_C2_CLOSE, 2'b10);
    svc_expect(SVC_C2_CLOSE, 2'b01);
    svc_expect(SVC_C2_OPEN, 2'b10);
    svc_expect(SVC_C2_WRITE, 2'b10);
    svc_expect(SVC_C2_CLOSE, 2'b10);
    diag_expect(8'h08, 4, 8'hC3);
    svc_expect(SVC_DXB_PUB, 2'b10);
    svc_expect(SVC_DXB_SUB, 2'b01);
    for (int i = 0; i < 6; i++)
      svc_expect(no[i], 2'b01);
  endtask

  // reset, then the scenarios in order
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_basic();
    t_fault();
    t_err();
    t_ext();
    results();
  end
endmodule // tb_top
`default_nettype wire
